// >>> rtl/psq_pkg.sv
// Purpose: Shared constants and types for page status tracking and queuing.
// Assumes: Eight-bit page status word, a small power of two number of pages.
// Notes: Command codes are local encodings of this block's command port.
package psq_pkg;
   // ---------------------------------------------------------------
   // Page status word layout
   // ---------------------------------------------------------------
   localparam int STS_LEN_BIT = 0;
   localparam int STS_DIR_BIT = 1;
   localparam int STS_EN_BIT = 2;
   localparam int STS_STATE_LO = 3;
   localparam int STS_BCAST_BIT = 6;
   localparam logic [7:0] STS_RESET = 8'h00;
   localparam logic [9:0] SHORT_MAX_BYTES = 10'h0FD;
   localparam logic [9:0] LONG_MIN_BYTES = 10'h101;
   // ---------------------------------------------------------------
   // Transmit page state codes
   // ---------------------------------------------------------------
   localparam logic [2:0] TX_STATE_IDLE = 3'h0;
   localparam logic [2:0] TX_STATE_WAITING = 3'h1;
   localparam logic [2:0] TX_STATE_SUCCESS = 3'h2;
   localparam logic [2:0] TX_STATE_ENQUIRY_TIMEOUT = 3'h3;
   localparam logic [2:0] TX_STATE_PACKET_TIMEOUT = 3'h4;
   localparam logic [2:0] TX_STATE_ABORTED = 3'h5;
   localparam logic [2:0] TX_STATE_FAILED = 3'h6;
   localparam logic [2:0] TX_STATE_REFUSAL_LIMIT = 3'h7;
   // ---------------------------------------------------------------
   // Receive page state codes
   // ---------------------------------------------------------------
   localparam logic [2:0] RX_STATE_IDLE = 3'h0;
   localparam logic [2:0] RX_STATE_ARMED = 3'h1;
   localparam logic [2:0] RX_STATE_FILLING = 3'h2;
   localparam logic [2:0] RX_STATE_FAILED = 3'h3;
   localparam logic [2:0] RX_STATE_SUCCESS = 3'h4;
   localparam logic [2:0] RX_STATE_ABORTED = 3'h5;
   // ---------------------------------------------------------------
   // Host commands and link outcomes
   // ---------------------------------------------------------------
   localparam logic [1:0] CMD_NONE = 2'h0;
   localparam logic [1:0] CMD_TX_ENABLE = 2'h1;
   localparam logic [1:0] CMD_RX_ENABLE = 2'h2;
   localparam logic [1:0] CMD_RX_DISABLE = 2'h3;
   localparam int TX_DONE_EVENT_BIT = 4;
   localparam int RX_DONE_EVENT_BIT = 5;
   localparam logic [7:0] REFUSAL_LIMIT_RESET = 8'h00;
   localparam logic [1:0] LIMIT_SHOW_CYCLES = 2'h2;

   typedef enum logic [2:0]
   {
      PSQ_TX_OK = 3'h0,
      PSQ_TX_ENQ_TIMEOUT = 3'h1,
      PSQ_TX_PAC_TIMEOUT = 3'h2,
      PSQ_TX_ERROR = 3'h3,
      PSQ_TX_ABORT_CMD = 3'h4
   } psq_tx_result_t;

   typedef enum logic [1:0]
   {
      PSQ_TQ_IDLE = 2'b00,
      PSQ_TQ_SEND = 2'b01,
      PSQ_TQ_SHOW = 2'b11
   } psq_tx_fsm_t;
endpackage : psq_pkg

// >>> rtl/psq_fifo_if.sv
// Purpose: Carrier between the page queue and its owner.
// Assumes: One clock, single producer and single consumer.
// Notes: Push is ignored when full, pop when empty.
`timescale 1ns/1ps
interface psq_fifo_if #(parameter int IW = 3);
   logic push;
   logic [IW-1:0] push_data;
   logic pop;
   logic [IW-1:0] head;
   logic empty;
   logic full;
   modport owner (output push, output push_data, output pop,
                  input head, input empty, input full);
   modport queue (input push, input push_data, input pop,
                  output head, output empty, output full);
endinterface : psq_fifo_if

// >>> rtl/psq_page_fifo.sv
// Purpose: First-in first-out queue of page indices.
// Assumes: Depth holds every page at once.
// Notes: Head is registered storage read at the read pointer.
`timescale 1ns/1ps
module psq_page_fifo
   import psq_pkg::*;
#(
   parameter int IW = 3,
   parameter int DEPTH = 8
)
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   psq_fifo_if.queue q
);
   localparam int PW = $clog2(DEPTH);
   logic [IW-1:0] mem [DEPTH];
   logic [PW-1:0] rd_ptr;
   logic [PW-1:0] wr_ptr;
   logic [PW:0] count;
   logic [PW-1:0] next_rd_ptr;
   logic [PW-1:0] next_wr_ptr;
   logic [PW:0] next_count;
   logic do_push;
   logic do_pop;

   assign q.head = mem[rd_ptr];
   assign q.empty = (count == '0);
   assign q.full = (count == (PW+1)'(DEPTH));

   always_comb
   begin
      do_push = q.push && !q.full;
      do_pop = q.pop && !q.empty;
      next_wr_ptr = do_push ? PW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = do_pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
      next_count = count;
      if (do_push && !do_pop)
      begin
         next_count = (PW+1)'(count + 1'b1);
      end
      else if (do_pop && !do_push)
      begin
         next_count = (PW+1)'(count - 1'b1);
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count <= '0;
      end
      else
      begin
         rd_ptr <= next_rd_ptr;
         wr_ptr <= next_wr_ptr;
         count <= next_count;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (do_push)
      begin
         mem[wr_ptr] <= q.push_data;
      end
   end
endmodule : psq_page_fifo

// >>> rtl/psq_page_status.sv
// Purpose: Per-page status words and enable-order queues for packet pages.
// Assumes: Link engines report outcomes for the page at the queue head.
// Notes: Commands and link events are one-cycle pulses on ref_clk_in.
`timescale 1ns/1ps
module psq_page_status
   import psq_pkg::*;
#(
   parameter int PAGES = 8,
   parameter int IW = 3
)
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic [1:0] page_cmd_in,
   input wire logic [IW-1:0] page_cmd_index_in,
   input wire logic page_status_query_cmd_in,
   input wire logic [IW-1:0] query_index_in,
   input wire logic refusal_limit_cmd_in,
   input wire logic [7:0] refusal_limit_in,
   input wire logic auto_abort_in,
   input wire logic tx_abort_cmd_in,
   input wire logic tx_start_in,
   input wire logic tx_refused_in,
   input wire logic tx_end_in,
   input wire logic [2:0] tx_result_in,
   input wire logic [9:0] tx_length_in,
   input wire logic rx_start_in,
   input wire logic rx_end_in,
   input wire logic rx_ok_in,
   input wire logic rx_broadcast_in,
   input wire logic [9:0] rx_length_in,
   output logic [7:0] command_argument_register_out,
   output logic tx_page_valid_out,
   output logic [IW-1:0] tx_page_out,
   output logic rx_page_valid_out,
   output logic [IW-1:0] rx_page_out,
   output logic [7:0] packet_event_out,
   output logic packet_event_valid_out
);
   logic [7:0] page_status [PAGES];
   logic [7:0] next_page_status [PAGES];
   logic [7:0] arg;
   logic [7:0] next_arg;
   logic [7:0] refusal_limit;
   logic [7:0] next_refusal_limit;
   logic [7:0] refusals;
   logic [7:0] next_refusals;
   logic [1:0] show_cnt;
   logic [1:0] next_show_cnt;
   logic [7:0] pkt_event;
   logic [7:0] next_pkt_event;
   logic pkt_event_valid;
   logic next_pkt_event_valid;
   logic rx_busy;
   logic next_rx_busy;
   logic limit_hit;
   psq_tx_fsm_t tx_fsm;
   psq_tx_fsm_t next_tx_fsm;
   psq_fifo_if #(.IW(IW)) txq ();
   psq_fifo_if #(.IW(IW)) rxq ();

   // ---------------------------------------------------------------
   // Enable-order queues
   // ---------------------------------------------------------------
   psq_page_fifo #(.IW(IW), .DEPTH(PAGES)) u_tx_queue
   (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .q(txq)
   );
   psq_page_fifo #(.IW(IW), .DEPTH(PAGES)) u_rx_queue
   (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .q(rxq)
   );

   function automatic logic long_flag(input logic [9:0] len);
      return len >= LONG_MIN_BYTES;
   endfunction : long_flag

   function automatic logic [7:0] with_state(input logic [7:0] w, input logic [2:0] s);
      logic [7:0] r;
      r = w;
      r[STS_STATE_LO +: 3] = s;
      return r;
   endfunction : with_state

   assign txq.push = (page_cmd_in == CMD_TX_ENABLE);
   assign txq.push_data = page_cmd_index_in;
   assign rxq.push = (page_cmd_in == CMD_RX_ENABLE);
   assign rxq.push_data = page_cmd_index_in;
   assign txq.pop = (tx_fsm == PSQ_TQ_SEND) && (tx_end_in || tx_abort_cmd_in || limit_hit);
   assign rxq.pop = !rxq.empty && (rx_end_in ||
                    (page_cmd_in == CMD_RX_DISABLE && page_cmd_index_in == rxq.head));
   assign limit_hit = (tx_fsm == PSQ_TQ_SEND) && tx_refused_in && auto_abort_in &&
                      refusal_limit != '0 && (8'(refusals + 1'b1) >= refusal_limit);
   assign tx_page_valid_out = !txq.empty;
   assign tx_page_out = txq.head;
   assign rx_page_valid_out = !rxq.empty;
   assign rx_page_out = rxq.head;
   assign command_argument_register_out = arg;
   assign packet_event_out = pkt_event;
   assign packet_event_valid_out = pkt_event_valid;

   // ---------------------------------------------------------------
   // Status words, transmit sequencer and events
   // ---------------------------------------------------------------
   always_comb
   begin
      logic [7:0] w;
      logic [2:0] tx_code;
      w = '0;
      tx_code = TX_STATE_SUCCESS;
      for (int i = 0; i < PAGES; i++)
      begin
         next_page_status[i] = page_status[i];
      end
      next_arg = arg;
      next_refusal_limit = refusal_limit_cmd_in ? refusal_limit_in : refusal_limit;
      next_refusals = refusals;
      next_show_cnt = show_cnt;
      next_tx_fsm = tx_fsm;
      next_pkt_event = pkt_event;
      next_pkt_event_valid = 1'b0;
      next_rx_busy = rx_busy;
      unique case (tx_fsm)
         PSQ_TQ_IDLE:
         begin
            next_refusals = '0;
            if (!txq.empty)
            begin
               next_tx_fsm = PSQ_TQ_SEND;
            end
         end
         PSQ_TQ_SEND:
         begin
            w = page_status[txq.head];
            if (tx_start_in)
            begin
               w[STS_LEN_BIT] = long_flag(tx_length_in);
            end
            if (tx_refused_in)
            begin
               next_refusals = 8'(refusals + 1'b1);
            end
            if (tx_refused_in && !auto_abort_in && refusal_limit != '0 &&
                8'(refusals + 1'b1) == refusal_limit)
            begin
               w = with_state(w, TX_STATE_REFUSAL_LIMIT);
               next_show_cnt = LIMIT_SHOW_CYCLES;
            end
            else if (show_cnt != '0)
            begin
               next_show_cnt = 2'(show_cnt - 1'b1);
               if (show_cnt == 2'h1)
               begin
                  w = with_state(w, TX_STATE_WAITING);
               end
            end
            if (tx_end_in || tx_abort_cmd_in || limit_hit)
            begin
               if (tx_abort_cmd_in || limit_hit)
               begin
                  tx_code = TX_STATE_ABORTED;
               end
               else
               begin
                  unique case (tx_result_in)
                     PSQ_TX_ENQ_TIMEOUT: tx_code = TX_STATE_ENQUIRY_TIMEOUT;
                     PSQ_TX_PAC_TIMEOUT: tx_code = TX_STATE_PACKET_TIMEOUT;
                     PSQ_TX_ERROR: tx_code = TX_STATE_FAILED;
                     PSQ_TX_ABORT_CMD: tx_code = TX_STATE_ABORTED;
                     default: tx_code = TX_STATE_SUCCESS;
                  endcase
               end
               w = with_state(w, tx_code);
               w[STS_EN_BIT] = 1'b0;
               next_pkt_event = 8'h00;
               next_pkt_event[TX_DONE_EVENT_BIT] = 1'b1;
               next_pkt_event[IW-1:0] = txq.head;
               next_pkt_event_valid = 1'b1;
               next_show_cnt = '0;
               next_tx_fsm = PSQ_TQ_SHOW;
            end
            next_page_status[txq.head] = w;
         end
         PSQ_TQ_SHOW:
         begin
            next_tx_fsm = PSQ_TQ_IDLE;
         end
         default:
         begin
            next_tx_fsm = PSQ_TQ_IDLE;
         end
      endcase
      if (!rxq.empty)
      begin
         w = page_status[rxq.head];
         if (rx_start_in)
         begin
            w = with_state(w, RX_STATE_FILLING);
            next_rx_busy = 1'b1;
         end
         if (rx_end_in)
         begin
            w = with_state(w, rx_ok_in ? RX_STATE_SUCCESS : RX_STATE_FAILED);
            w[STS_LEN_BIT] = long_flag(rx_length_in);
            w[STS_BCAST_BIT] = rx_broadcast_in;
            w[STS_EN_BIT] = 1'b0;
            next_rx_busy = 1'b0;
            next_pkt_event = 8'h00;
            next_pkt_event[RX_DONE_EVENT_BIT] = 1'b1;
            next_pkt_event[IW-1:0] = rxq.head;
            next_pkt_event_valid = 1'b1;
         end
         next_page_status[rxq.head] = w;
      end
      if (page_cmd_in == CMD_RX_DISABLE)
      begin
         w = page_status[page_cmd_index_in];
         if (!w[STS_DIR_BIT] && w[STS_EN_BIT])
         begin
            w[STS_EN_BIT] = 1'b0;
            w = with_state(w, (rx_busy && rxq.head == page_cmd_index_in) ?
                           RX_STATE_ABORTED : RX_STATE_IDLE);
            next_page_status[page_cmd_index_in] = w;
            if (rxq.head == page_cmd_index_in)
            begin
               next_rx_busy = 1'b0;
            end
         end
      end
      if (page_cmd_in == CMD_TX_ENABLE || page_cmd_in == CMD_RX_ENABLE)
      begin
         w = STS_RESET;
         w[STS_DIR_BIT] = (page_cmd_in == CMD_TX_ENABLE);
         w[STS_EN_BIT] = 1'b1;
         w = with_state(w, TX_STATE_WAITING);
         next_page_status[page_cmd_index_in] = w;
      end
      if (page_status_query_cmd_in)
      begin
         next_arg = page_status[query_index_in];
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         for (int i = 0; i < PAGES; i++)
         begin
            page_status[i] <= STS_RESET;
         end
         arg <= '0;
         refusal_limit <= REFUSAL_LIMIT_RESET;
         refusals <= '0;
         show_cnt <= '0;
         tx_fsm <= PSQ_TQ_IDLE;
         pkt_event <= '0;
         pkt_event_valid <= 1'b0;
         rx_busy <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < PAGES; i++)
         begin
            page_status[i] <= next_page_status[i];
         end
         arg <= next_arg;
         refusal_limit <= next_refusal_limit;
         refusals <= next_refusals;
         show_cnt <= next_show_cnt;
         tx_fsm <= next_tx_fsm;
         pkt_event <= next_pkt_event;
         pkt_event_valid <= next_pkt_event_valid;
         rx_busy <= next_rx_busy;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   query_loads_arg_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      page_status_query_cmd_in && page_cmd_in == CMD_NONE && !rx_end_in && tx_fsm != PSQ_TQ_SEND
      |=> arg == $past(page_status[query_index_in]))
      else $error("Query did not load the argument register.");
   enable_clears_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      page_cmd_in == CMD_TX_ENABLE |=> page_status[$past(page_cmd_index_in)] == 8'h0E)
      else $error("Transmit enable did not reset the status word.");
   rx_enable_word_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      page_cmd_in == CMD_RX_ENABLE |=> page_status[$past(page_cmd_index_in)] == 8'h0C)
      else $error("Receive enable gave a wrong status word.");
   tx_event_tag_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      txq.pop |=> pkt_event_valid && pkt_event[TX_DONE_EVENT_BIT] &&
      pkt_event[IW-1:0] == $past(txq.head))
      else $error("Transmit completion event missing or mistagged.");
   rx_event_tag_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      rx_end_in && !rxq.empty && !txq.pop |=> pkt_event_valid &&
      pkt_event[RX_DONE_EVENT_BIT] && pkt_event[IW-1:0] == $past(rxq.head))
      else $error("Receive completion event missing or mistagged.");
   abort_code_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      tx_fsm == PSQ_TQ_SEND && tx_abort_cmd_in && !(page_cmd_in != CMD_NONE &&
      page_cmd_index_in == txq.head) |=> page_status[$past(txq.head)][5:3] == 3'h5)
      else $error("Transmit abort did not report code 5.");
   sequence limit_seen_s;
      tx_fsm == PSQ_TQ_SEND && tx_refused_in && !auto_abort_in && refusal_limit != '0 &&
      8'(refusals + 1'b1) == refusal_limit && !tx_end_in && !tx_abort_cmd_in;
   endsequence
   limit_brief_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      limit_seen_s |=> show_cnt == 2'h2 ##1 show_cnt <= 2'h1 ##1 show_cnt == 2'h0)
      else $error("Refusal limit code not brief.");
   limit_abort_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      limit_hit |=> tx_fsm == PSQ_TQ_SHOW && pkt_event_valid)
      else $error("Auto abort at limit did not complete the page.");
endmodule : psq_page_status

// >>> dv/psq_link_model.sv
// Purpose: Link engine stand-in that serves the head transmit page.
// Assumes: Block inputs change at the falling clock edge.
// Notes: Outcome, length, refusals and hold time are levels set by the bench.
`timescale 1ns/1ps
module psq_link_model
(
   input wire logic ref_clk_in,
   input wire logic serve_in,
   input wire logic tx_page_valid_in,
   input wire logic [2:0] result_in,
   input wire logic [9:0] length_in,
   input wire logic [3:0] refusals_in,
   input wire logic [5:0] hold_in,
   output logic tx_start_out,
   output logic tx_refused_out,
   output logic tx_end_out,
   output logic [2:0] tx_result_out,
   output logic [9:0] tx_length_out
);
   initial
   begin
      tx_start_out = 1'b0;
      tx_refused_out = 1'b0;
      tx_end_out = 1'b0;
      tx_result_out = 3'h7;
      tx_length_out = 10'h3FF;
      forever
      begin
         @(negedge ref_clk_in);
         if (serve_in && tx_page_valid_in)
         begin
            repeat (6) @(negedge ref_clk_in);
            tx_start_out = 1'b1;
            tx_length_out = length_in;
            @(negedge ref_clk_in);
            tx_start_out = 1'b0;
            // Stale fields show the inverse so a late sample cannot match by chance.
            tx_length_out = ~length_in;
            repeat (refusals_in)
            begin
               tx_refused_out = 1'b1;
               @(negedge ref_clk_in);
               tx_refused_out = 1'b0;
               @(negedge ref_clk_in);
            end
            repeat (hold_in) @(negedge ref_clk_in);
            tx_end_out = 1'b1;
            tx_result_out = result_in;
            @(negedge ref_clk_in);
            tx_end_out = 1'b0;
            tx_result_out = ~result_in;
            repeat (4) @(negedge ref_clk_in);
         end
      end
   end
endmodule : psq_link_model

// >>> dv/page_status_and_queuing_test.sv
// Purpose: Self-checking bench for page status tracking and queuing.
// Assumes: Inputs change at the falling edge; the query answer lands one cycle later.
// Notes: The driver queues expected words; the monitor pops one per answer or event.
`timescale 1ns/1ps
module page_status_and_queuing_test;
   import psq_pkg::*;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [1:0] page_cmd_in = CMD_NONE;
   logic [2:0] page_cmd_index_in = 3'h0;
   logic [2:0] query_index_in = 3'h0;
   logic page_status_query_cmd_in = 1'b0;
   logic refusal_limit_cmd_in = 1'b0;
   logic [7:0] refusal_limit_in = 8'h00;
   logic auto_abort_in = 1'b0;
   logic tx_abort_cmd_in = 1'b0;
   logic rx_start_in = 1'b0;
   logic rx_end_in = 1'b0;
   logic rx_ok_in = 1'b0;
   logic rx_broadcast_in = 1'b0;
   logic [9:0] rx_length_in = 10'h000;
   logic tx_start_in, tx_refused_in, tx_end_in;
   logic [2:0] tx_result_in, tx_page_out, rx_page_out;
   logic [9:0] tx_length_in;
   logic [7:0] command_argument_register_out, packet_event_out;
   logic tx_page_valid_out, rx_page_valid_out, packet_event_valid_out;
   logic serve = 1'b0;
   logic [2:0] result = 3'h0;
   logic [9:0] plen = 10'h000;
   logic [3:0] nref = 4'h0;
   logic [5:0] hold = 6'h02;
   logic q_took = 1'b0;
   logic [31:0] seed = 32'h0001_55E9;
   logic [7:0] exp_sts[$];
   logic [7:0] exp_ev[$];
   logic [2:0] codes[5] = '{TX_STATE_SUCCESS, TX_STATE_ENQUIRY_TIMEOUT,
      TX_STATE_PACKET_TIMEOUT, TX_STATE_FAILED, TX_STATE_ABORTED};
   int num_errors = 0;
   int cmp_count = 0;

   always #50 ref_clk_in = ~ref_clk_in;

   psq_page_status u_dut (.*);
   psq_link_model u_link (.ref_clk_in(ref_clk_in), .serve_in(serve),
      .tx_page_valid_in(tx_page_valid_out), .result_in(result), .length_in(plen),
      .refusals_in(nref), .hold_in(hold), .tx_start_out(tx_start_in),
      .tx_refused_out(tx_refused_in), .tx_end_out(tx_end_in),
      .tx_result_out(tx_result_in), .tx_length_out(tx_length_in));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         num_errors++;
      end
   endtask : check8

   task automatic check_event(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("unexpected event at %0t: got %h expected %h", $time, got, exp);
         num_errors++;
      end
   endtask : check_event

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   task tick(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask : tick

   task command(input logic [1:0] c, input logic [2:0] p);
      page_cmd_in = c;
      page_cmd_index_in = p;
      tick(1);
      page_cmd_in = CMD_NONE;
      tick(2);
   endtask : command

   task query(input logic [2:0] p, input logic [7:0] w);
      exp_sts.push_back(w);
      query_index_in = p;
      page_status_query_cmd_in = 1'b1;
      tick(1);
      page_status_query_cmd_in = 1'b0;
      tick(1);
   endtask : query

   // Holds the query up until the state field shows the code, within a bound.
   task poll_state(input logic [2:0] p, input logic [2:0] code);
      int n;
      n = 0;
      query_index_in = p;
      page_status_query_cmd_in = 1'b1;
      tick(1);
      while (command_argument_register_out[5:3] !== code && n < 40)
      begin
         tick(1);
         n++;
      end
      page_status_query_cmd_in = 1'b0;
      check8({5'h00, command_argument_register_out[5:3]}, {5'h00, code});
      if (n >= 40)
      begin
         tally_and_finish();
      end
      tick(1);
   endtask : poll_state

   task wait_events;
      int n;
      n = 0;
      while (exp_ev.size() > 0 && n < 600)
      begin
         tick(1);
         n++;
      end
      if (exp_ev.size() > 0)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, exp_ev.size(), 0);
         num_errors++;
         tally_and_finish();
      end
      tick(2);
   endtask : wait_events

   task rx_frame(input logic [2:0] p, input logic ok, input logic bc, input logic [9:0] len);
      rx_start_in = 1'b1;
      tick(1);
      rx_start_in = 1'b0;
      tick(2);
      query(p, 8'h14);
      rx_ok_in = ok;
      rx_broadcast_in = bc;
      rx_length_in = len;
      rx_end_in = 1'b1;
      exp_ev.push_back({5'h04, p});
      tick(1);
      rx_end_in = 1'b0;
      rx_length_in = ~len;
      wait_events();
   endtask : rx_frame

   always @(posedge ref_clk_in)
      q_took <= page_status_query_cmd_in;

   always @(negedge ref_clk_in)
   begin
      if (q_took && exp_sts.size() > 0)
         check8(command_argument_register_out, exp_sts.pop_front());
      if (packet_event_valid_out === 1'b1)
      begin
         if (exp_ev.size() > 0)
            check_event(packet_event_out, exp_ev.pop_front());
         else
            check_event(packet_event_out, 8'hFF);
      end
   end

   initial
   begin
      logic [2:0] p;
      logic lng;
      logic [9:0] off;
      tick(16);
      rst_n_in = 1'b1;
      tick(1);
      for (int i = 0; i < 8; i++)
         query(3'(i), STS_RESET);
      serve = 1'b1;
      for (int k = 0; k < 5; k++)
      begin
         seed = xs(seed);
         p = seed[10:8];
         lng = (k < 2) ? k[0] : seed[0];
         off = (k < 2) ? 10'h000 : {4'h0, seed[6:1]};
         plen = lng ? LONG_MIN_BYTES + off : SHORT_MAX_BYTES - off;
         result = k[2:0];
         exp_ev.push_back({5'h02, p});
         command(CMD_TX_ENABLE, p);
         query(p, 8'h0E);
         wait_events();
         query(p, {2'b00, codes[k], 2'b01, lng});
      end
      $display("test tx outcomes done");
      serve = 1'b0;
      result = 3'h0;
      plen = LONG_MIN_BYTES;
      for (int i = 0; i < 8; i++)
      begin
         p = seed[2:0] + 3'(5 * i);
         exp_ev.push_back({5'h02, p});
         command(CMD_TX_ENABLE, p);
      end
      check8({5'h00, tx_page_out}, {5'h00, seed[2:0]});
      serve = 1'b1;
      wait_events();
      $display("test tx order done");
      refusal_limit_in = 8'h02;
      refusal_limit_cmd_in = 1'b1;
      tick(1);
      refusal_limit_cmd_in = 1'b0;
      nref = 4'h2;
      hold = 6'h1E;
      plen = SHORT_MAX_BYTES;
      exp_ev.push_back(8'h16);
      command(CMD_TX_ENABLE, 3'h6);
      poll_state(3'h6, TX_STATE_REFUSAL_LIMIT);
      poll_state(3'h6, TX_STATE_WAITING);
      wait_events();
      query(3'h6, 8'h12);
      auto_abort_in = 1'b1;
      exp_ev.push_back(8'h13);
      command(CMD_TX_ENABLE, 3'h3);
      wait_events();
      query(3'h3, 8'h2A);
      tick(60);
      auto_abort_in = 1'b0;
      nref = 4'h0;
      exp_ev.push_back(8'h12);
      command(CMD_TX_ENABLE, 3'h2);
      tick(8);
      tx_abort_cmd_in = 1'b1;
      tick(1);
      tx_abort_cmd_in = 1'b0;
      wait_events();
      query(3'h2, 8'h2A);
      tick(60);
      $display("test refusal and abort done");
      seed = xs(seed);
      command(CMD_RX_ENABLE, 3'h4);
      command(CMD_RX_ENABLE, 3'h2);
      command(CMD_RX_ENABLE, 3'h7);
      query(3'h4, 8'h0C);
      check8({5'h00, rx_page_out}, 8'h04);
      rx_frame(3'h4, 1'b1, 1'b1, LONG_MIN_BYTES + {4'h0, seed[5:0]});
      query(3'h4, 8'h61);
      check8({5'h00, rx_page_out}, 8'h02);
      rx_frame(3'h2, 1'b0, 1'b0, SHORT_MAX_BYTES - {4'h0, seed[11:6]});
      query(3'h2, 8'h18);
      check8({5'h00, rx_page_out}, 8'h07);
      rx_start_in = 1'b1;
      tick(1);
      rx_start_in = 1'b0;
      command(CMD_RX_DISABLE, 3'h7);
      tick(3);
      query(3'h7, 8'h28);
      check8({7'h00, rx_page_valid_out}, 8'h00);
      $display("test rx pages done");
      tally_and_finish();
   end
endmodule : page_status_and_queuing_test
